// file: rtl/cpes_scanner.sv
// Purpose: timers and shared endpoint scan for continuity loss and extraction
// Assumes: one 50 MHz clock, frame pipeline and register bus on the same clock
// Notes: endpoint tables are flops; the scan shares their single access port
//
// Summary of operation
// - processor disabled: config writable, frames ignored
// - ethernet expiry bumps miss, ccm clears, threshold alarms
// - lm timer expiry marks next tx ccm
// - mpls expiry bumps miss, bfd clears, programmable threshold
// - scan visits all, updates assigned endpoints only
// - one endpoint per cycle, stall on frame/csr
// - scan disabled: timers held at zero, never expire
// - base tick every configured cycle count
// - seven continuity timers count ticks, own period
// - ethernet alarm after seven consecutive empty scans
// - force mask starts scan without expiry
// - scan disable aborts, zeroes timers, keeps misses
// - active mask shows timers in current scan
// - sticky begun and done flags
// - expiry during own scan sets overrun flag
// - two extraction timers share tick and scan
// - extraction expiry uses wrapping 3-bit slot counter
// - forced extraction scan uses forced slot value
// - five groups each mapped to one extraction timer
// - group updated on slot, timer, enable match
// - groups 1-4 set bits, group 5 copies peer
// - periodic extraction always single shot
`timescale 1ns/100ps
module cpes_scanner
    import cpes_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic frm_valid,
    input wire logic [CPES_EPW-1:0] frm_ep,
    input wire logic frm_ccm_ok,
    input wire logic frm_bfd_ok,
    input wire logic frm_tx_ccm,
    input wire logic frm_extract_taken,
    output logic frm_as_ccm_lm,
    output logic [CPES_N_GRP-1:0] frm_extract_bits,
    output logic frm_single_shot,
    output logic loss_event,
    output logic [CPES_EPW-1:0] loss_event_ep
);
    typedef enum logic {CPES_IDLE, CPES_RUN} cpes_state_e;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic ack_r;
    logic csr_req;
    logic wr_go;
    logic proc_en_r;
    logic scan_en_r;
    logic [CPES_TICKW-1:0] tick_cycles_r;
    logic [CPES_SLOTW-1:0] forced_slot_r;
    logic [CPES_N_GRP-1:0] grp_tmr_r;
    logic [CPES_MISSW-1:0] bfd_th_r;
    logic [CPES_EPW-1:0] ep_sel_r;
    logic [CPES_TMRW-1:0] period_r [CPES_N_TMR];
    logic [CPES_N_TMR-1:0] force_nxt;
    logic begun_r;
    logic done_r;
    logic ovr_r;
    logic [CPES_N_TMR-1:0] act_r;

    assign csr_req = avs_read | avs_write;
    // one wait cycle per access; data and write land on the released edge
    assign avs_waitrequest = csr_req & ~ack_r;
    assign wr_go = avs_write & ack_r;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= csr_req & ~ack_r;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            proc_en_r <= 1'b0;
            scan_en_r <= 1'b0;
            tick_cycles_r <= CPES_TICK_RST;
            forced_slot_r <= '0;
            grp_tmr_r <= '0;
            bfd_th_r <= CPES_BFDTH_RST;
            ep_sel_r <= '0;
            for (int i = 0; i < CPES_N_TMR; i++) begin
                period_r[i] <= '0;
            end
        end else if (wr_go) begin
            // configuration stays writable while the processor is off
            case (avs_address)
                CPES_A_CTRL: begin
                    proc_en_r <= avs_writedata[CPES_B_PEN];
                    scan_en_r <= avs_writedata[CPES_B_SEN];
                end
                CPES_A_TICK: tick_cycles_r <= avs_writedata[CPES_TICKW-1:0];
                CPES_A_FSLOT: forced_slot_r <= avs_writedata[CPES_SLOTW-1:0];
                CPES_A_GTMR: grp_tmr_r <= avs_writedata[CPES_N_GRP-1:0];
                CPES_A_BFDTH: bfd_th_r <= avs_writedata[CPES_MISSW-1:0];
                CPES_A_EPSEL: ep_sel_r <= avs_writedata[CPES_EPW-1:0];
                default: begin
                    for (int i = 0; i < CPES_N_TMR; i++) begin
                        if (avs_address == CPES_A_PER0 + 6'(i)) begin
                            period_r[i] <= avs_writedata[CPES_TMRW-1:0];
                        end
                    end
                end
            endcase
        end
    end

    assign force_nxt = (wr_go && avs_address == CPES_A_FORCE) ?
        avs_writedata[CPES_N_TMR-1:0] : '0;

    // ----------------------------------------------------------------
    // endpoint tables
    // ----------------------------------------------------------------
    logic [16:0] ep_cfg_r [CPES_N_EP];
    logic [CPES_MISSW-1:0] miss_r [CPES_N_EP];
    logic [CPES_N_EP-1:0] loss_r;
    logic [CPES_N_EP-1:0] lm_pend_r;
    logic [CPES_N_GRP-1:0] extr_r [CPES_N_EP];
    logic [CPES_N_EP-1:0] once_r;
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            CPES_A_CTRL: begin
                rd_mux[CPES_B_PEN] = proc_en_r;
                rd_mux[CPES_B_SEN] = scan_en_r;
            end
            CPES_A_TICK: rd_mux[CPES_TICKW-1:0] = tick_cycles_r;
            CPES_A_STAT: begin
                rd_mux[CPES_N_TMR-1:0] = act_r;
                rd_mux[CPES_B_BEGUN] = begun_r;
                rd_mux[CPES_B_DONE] = done_r;
                rd_mux[CPES_B_OVR] = ovr_r;
            end
            CPES_A_FSLOT: rd_mux[CPES_SLOTW-1:0] = forced_slot_r;
            CPES_A_GTMR: rd_mux[CPES_N_GRP-1:0] = grp_tmr_r;
            CPES_A_BFDTH: rd_mux[CPES_MISSW-1:0] = bfd_th_r;
            CPES_A_EPSEL: rd_mux[CPES_EPW-1:0] = ep_sel_r;
            CPES_A_EPCFG: rd_mux[16:0] = ep_cfg_r[ep_sel_r];
            CPES_A_EPST: begin
                rd_mux[3:0] = miss_r[ep_sel_r];
                rd_mux[4] = loss_r[ep_sel_r];
                rd_mux[5] = lm_pend_r[ep_sel_r];
                rd_mux[10:6] = extr_r[ep_sel_r];
                rd_mux[11] = once_r[ep_sel_r];
            end
            default: begin
                for (int i = 0; i < CPES_N_TMR; i++) begin
                    if (avs_address == CPES_A_PER0 + 6'(i)) begin
                        rd_mux[CPES_TMRW-1:0] = period_r[i];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // base tick and timers
    // ----------------------------------------------------------------
    logic [CPES_TICKW-1:0] tick_cnt_r;
    logic tick;
    logic [CPES_TMRW-1:0] tmr_r [CPES_N_TMR];
    logic [CPES_N_TMR-1:0] exp_w;
    logic [CPES_SLOTW-1:0] slot_r [CPES_N_EXT];

    assign tick = scan_en_r && (tick_cnt_r + 20'h00001 >= tick_cycles_r);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= '0;
        end else if (!scan_en_r || tick) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 20'h00001;
        end
    end

    always_comb begin
        for (int i = 0; i < CPES_N_TMR; i++) begin
            exp_w[i] = tick && period_r[i] != '0 &&
                (tmr_r[i] + 16'h0001 >= period_r[i]);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CPES_N_TMR; i++) begin
                tmr_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CPES_N_TMR; i++) begin
                if (!scan_en_r || exp_w[i]) begin
                    tmr_r[i] <= '0;
                end else if (tick) begin
                    tmr_r[i] <= tmr_r[i] + 16'h0001;
                end
            end
        end
    end

    // slot counters are private; the scan uses the value before the bump
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            slot_r[0] <= '0;
            slot_r[1] <= '0;
        end else begin
            for (int e = 0; e < CPES_N_EXT; e++) begin
                if (exp_w[CPES_N_CONT+e]) begin
                    slot_r[e] <= slot_r[e] + 3'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // scan control
    // ----------------------------------------------------------------
    cpes_state_e st_r;
    logic [CPES_N_TMR-1:0] pend_r;
    logic [CPES_SLOTW-1:0] pslot_r [CPES_N_EXT];
    logic [CPES_SLOTW-1:0] aslot_r [CPES_N_EXT];
    logic [CPES_EPW-1:0] idx_r;
    logic frm_go;
    logic step;
    logic start;
    logic last;

    assign frm_go = frm_valid & proc_en_r;
    assign step = (st_r == CPES_RUN) && !frm_go && !csr_req;
    assign start = scan_en_r && (st_r == CPES_IDLE) && (pend_r != '0);
    assign last = step && idx_r == CPES_EPW'(CPES_N_EP - 1);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= CPES_IDLE;
            pend_r <= '0;
            act_r <= '0;
            idx_r <= '0;
            for (int e = 0; e < CPES_N_EXT; e++) begin
                pslot_r[e] <= '0;
                aslot_r[e] <= '0;
            end
        end else if (!scan_en_r) begin
            st_r <= CPES_IDLE;
            pend_r <= '0;
            act_r <= '0;
            idx_r <= '0;
        end else begin
            case (st_r)
                CPES_IDLE: begin
                    if (start) begin
                        st_r <= CPES_RUN;
                        act_r <= pend_r;
                        for (int e = 0; e < CPES_N_EXT; e++) begin
                            aslot_r[e] <= pslot_r[e];
                        end
                    end
                end
                CPES_RUN: begin
                    if (step) begin
                        idx_r <= idx_r + 8'h01;
                    end
                    if (last) begin
                        st_r <= CPES_IDLE;
                        act_r <= '0;
                        idx_r <= '0;
                    end
                end
                default: st_r <= CPES_IDLE;
            endcase
            pend_r <= (start ? '0 : pend_r) | exp_w | force_nxt;
            for (int e = 0; e < CPES_N_EXT; e++) begin
                if (force_nxt[CPES_N_CONT+e]) begin
                    pslot_r[e] <= forced_slot_r;
                end else if (exp_w[CPES_N_CONT+e]) begin
                    pslot_r[e] <= slot_r[e];
                end
            end
        end
    end

    // sticky flags: a set in the clearing cycle wins
    logic w1c;
    assign w1c = wr_go && avs_address == CPES_A_STAT;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            begun_r <= 1'b0;
            done_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            begun_r <= (begun_r & ~(w1c & avs_writedata[CPES_B_BEGUN])) | start;
            done_r <= (done_r & ~(w1c & avs_writedata[CPES_B_DONE])) | last;
            ovr_r <= (ovr_r & ~(w1c & avs_writedata[CPES_B_OVR])) |
                (|(exp_w & (pend_r | act_r)));
        end
    end

    // ----------------------------------------------------------------
    // endpoint update: scan, frames and software share the tables
    // ----------------------------------------------------------------
    logic [16:0] cur;
    logic [CPES_MISSW-1:0] th;
    logic [CPES_N_GRP-1:0] gup;

    assign cur = ep_cfg_r[idx_r];
    assign th = cur[0] ? bfd_th_r : CPES_ETH_MISS_MAX;

    always_comb begin
        for (int g = 0; g < CPES_N_GRP; g++) begin
            gup[g] = act_r[CPES_N_CONT + 32'(grp_tmr_r[g])] &&
                cur[9:7] == aslot_r[grp_tmr_r[g]] && cur[10+g];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < CPES_N_EP; i++) begin
                ep_cfg_r[i] <= CPES_EPCFG_RST;
                miss_r[i] <= '0;
                extr_r[i] <= '0;
            end
            loss_r <= '0;
            lm_pend_r <= '0;
            once_r <= '0;
            loss_event <= 1'b0;
            loss_event_ep <= '0;
        end else begin
            loss_event <= 1'b0;
            if (step) begin
                if (cur[3:1] != CPES_SEL_NONE && act_r[cur[3:1]] &&
                        miss_r[idx_r] < th) begin
                    miss_r[idx_r] <= miss_r[idx_r] + 4'h1;
                    if (miss_r[idx_r] + 4'h1 == th) begin
                        loss_r[idx_r] <= 1'b1;
                        loss_event <= 1'b1;
                        loss_event_ep <= idx_r;
                    end
                end
                if (!cur[0] && cur[6:4] != CPES_SEL_NONE && act_r[cur[6:4]]) begin
                    lm_pend_r[idx_r] <= 1'b1;
                end
                for (int g = 0; g < CPES_N_GRP-1; g++) begin
                    if (gup[g]) begin
                        extr_r[idx_r][g] <= 1'b1;
                    end
                end
                if (gup[CPES_N_GRP-1]) begin
                    extr_r[idx_r][CPES_N_GRP-1] <= cur[15];
                end
                if (|gup) begin
                    once_r[idx_r] <= 1'b1;
                end
            end
            if (frm_go) begin
                if ((frm_ccm_ok && !ep_cfg_r[frm_ep][0]) ||
                        (frm_bfd_ok && ep_cfg_r[frm_ep][0])) begin
                    miss_r[frm_ep] <= '0;
                    loss_r[frm_ep] <= 1'b0;
                end
                if (frm_tx_ccm) begin
                    lm_pend_r[frm_ep] <= 1'b0;
                end
                if (frm_extract_taken && (once_r[frm_ep] || ep_cfg_r[frm_ep][16])) begin
                    extr_r[frm_ep] <= '0;
                    once_r[frm_ep] <= 1'b0;
                end
            end
            if (wr_go && avs_address == CPES_A_EPCFG) begin
                ep_cfg_r[ep_sel_r] <= avs_writedata[16:0];
            end
        end
    end

    // frame-side answers, one cycle after the lookup
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            frm_as_ccm_lm <= 1'b0;
            frm_extract_bits <= '0;
            frm_single_shot <= 1'b0;
        end else begin
            frm_as_ccm_lm <= frm_go && frm_tx_ccm && lm_pend_r[frm_ep];
            frm_extract_bits <= frm_go ? extr_r[frm_ep] : '0;
            frm_single_shot <= frm_go && (once_r[frm_ep] || ep_cfg_r[frm_ep][16]);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_stall_freeze: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (st_r == CPES_RUN && (frm_go || csr_req) && scan_en_r) |=> $stable(idx_r))
        else $error("scan index moved during a stall");
    a_step_adv: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (step && !last && scan_en_r) |=> idx_r == $past(idx_r) + 8'h01)
        else $error("scan index did not advance");
    a_dis_timers: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !scan_en_r |=> (tmr_r[0] == '0 && tmr_r[8] == '0 && exp_w == '0))
        else $error("timer ran with scan disabled");
    a_dis_abort: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !scan_en_r |=> (st_r == CPES_IDLE && act_r == '0))
        else $error("scan not aborted");
    a_tick_gap: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (tick && tick_cycles_r == 20'h00003 && $stable(tick_cycles_r) && scan_en_r)
        |=> !tick ##1 !tick)
        else $error("base tick came too early");
    a_begun_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        start |=> begun_r && st_r == CPES_RUN && act_r != '0)
        else $error("scan start not flagged");
    a_done_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (last && scan_en_r) |=> done_r && st_r == CPES_IDLE)
        else $error("scan end not flagged");
    a_overrun: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (|(exp_w & act_r)) |=> ovr_r)
        else $error("overrun not flagged");
    a_force_scan: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (force_nxt[0] && scan_en_r && st_r == CPES_IDLE) |=> pend_r[0] ##1 act_r[0])
        else $error("forced scan not started");
    a_lm_answer: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (frm_valid && !proc_en_r) |=> !frm_as_ccm_lm && frm_extract_bits == '0)
        else $error("frame answered while disabled");

    c_scan_done: cover property (@(posedge clk_sys) disable iff (sys_rst) last);
    c_ext_scan: cover property (@(posedge clk_sys) disable iff (sys_rst) step && |gup);
    c_loss: cover property (@(posedge clk_sys) disable iff (sys_rst) loss_event);
    c_overrun: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(ovr_r));
endmodule

// file: rtl/cpes_pkg.sv
// Purpose: shared constants of the continuity and periodic extract scanner
// Assumes: 32-bit Avalon-MM register bus, word addressing
// Notes: timer index 0..6 continuity timers, 7..8 extraction timers
package cpes_pkg;
    localparam int CPES_N_CONT = 7;
    localparam int CPES_N_EXT = 2;
    localparam int CPES_N_TMR = 9;
    localparam int CPES_N_GRP = 5;
    localparam int CPES_N_EP = 203;
    localparam int CPES_EPW = 8;
    localparam int CPES_SLOTW = 3;
    localparam int CPES_MISSW = 4;
    localparam int CPES_TMRW = 16;
    localparam int CPES_TICKW = 20;
    // continuity-loss threshold for ethernet endpoints: seven empty scans
    localparam logic [3:0] CPES_ETH_MISS_MAX = 4'h7;
    localparam logic [2:0] CPES_SEL_NONE = 3'h7;
    // register word addresses
    localparam logic [5:0] CPES_A_CTRL = 6'h00;
    localparam logic [5:0] CPES_A_TICK = 6'h01;
    localparam logic [5:0] CPES_A_FORCE = 6'h02;
    localparam logic [5:0] CPES_A_STAT = 6'h03;
    localparam logic [5:0] CPES_A_FSLOT = 6'h04;
    localparam logic [5:0] CPES_A_GTMR = 6'h05;
    localparam logic [5:0] CPES_A_BFDTH = 6'h06;
    localparam logic [5:0] CPES_A_EPSEL = 6'h07;
    localparam logic [5:0] CPES_A_EPCFG = 6'h08;
    localparam logic [5:0] CPES_A_EPST = 6'h09;
    localparam logic [5:0] CPES_A_PER0 = 6'h10;
    // field positions
    localparam int CPES_B_PEN = 0;
    localparam int CPES_B_SEN = 1;
    localparam int CPES_B_BEGUN = 16;
    localparam int CPES_B_DONE = 17;
    localparam int CPES_B_OVR = 18;
    // reset values
    localparam logic [19:0] CPES_TICK_RST = 20'h0C350;
    localparam logic [3:0] CPES_BFDTH_RST = 4'h3;
    // endpoint config word: [0] mpls, [3:1] cont sel, [6:4] lm sel,
    // [9:7] slot, [14:10] group enables, [15] peer value, [16] single shot
    localparam logic [16:0] CPES_EPCFG_RST = 17'h0007E;
endpackage

// file: tb/cpes_frame_model.sv
// Purpose: frame pipeline stand-in driving the scanner lookup port
// Assumes: same clock as the scanner
// Notes: index bus shows the inverted endpoint between lookups
`timescale 1ns/100ps
module cpes_frame_model
    import cpes_pkg::*;
(
    input wire logic clk_sys,
    output logic frm_valid,
    output logic [CPES_EPW-1:0] frm_ep,
    output logic frm_ccm_ok,
    output logic frm_bfd_ok,
    output logic frm_tx_ccm,
    output logic frm_extract_taken,
    input wire logic frm_as_ccm_lm
);
    int lm_hits = 0;
    initial begin
        {frm_valid, frm_ccm_ok, frm_bfd_ok, frm_tx_ccm, frm_extract_taken} = '0;
        frm_ep = 8'hFF;
    end
    // k is {extract taken, tx ccm, bfd ok, ccm ok}
    task send(input logic [7:0] ep, input logic [3:0] k);
        frm_valid <= 1'b1;
        frm_ep <= ep;
        {frm_extract_taken, frm_tx_ccm, frm_bfd_ok, frm_ccm_ok} <= k;
        @(posedge clk_sys);
        frm_valid <= 1'b0;
        frm_ep <= ~ep;
        {frm_extract_taken, frm_tx_ccm, frm_bfd_ok, frm_ccm_ok} <= 4'h0;
        repeat (2) @(posedge clk_sys);
    endtask
    always @(negedge clk_sys) begin
        if (frm_as_ccm_lm === 1'b1) lm_hits++;
    end
endmodule

// file: tb/cpes_scanner_tb_top.sv
// Purpose: self-checking bench for the scanner
// Assumes: counts shortened through tick and period registers
// Notes: bus answers taken at the rising edge that shows waitrequest low
`timescale 1ns/100ps
module cpes_scanner_tb_top
    import cpes_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] av_a = '0;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wd = '0;
    logic [31:0] avs_readdata, d;
    logic [4:0] x_bits;
    logic x_ss;
    logic [5:0] x_seen = '0;
    logic avs_waitrequest, frm_valid, frm_ccm_ok, frm_bfd_ok, frm_tx_ccm;
    logic frm_extract_taken, frm_as_ccm_lm, loss_event;
    logic [7:0] frm_ep, loss_event_ep, loss_ep;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_loss = 0;

    cpes_scanner i_cpes_scanner (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(av_a), .avs_read(av_rd), .avs_write(av_wr),
        .avs_writedata(av_wd), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid), .frm_ep(frm_ep),
        .frm_ccm_ok(frm_ccm_ok), .frm_bfd_ok(frm_bfd_ok), .frm_tx_ccm(frm_tx_ccm),
        .frm_extract_taken(frm_extract_taken), .frm_as_ccm_lm(frm_as_ccm_lm),
        .frm_extract_bits(x_bits), .frm_single_shot(x_ss), .loss_event(loss_event),
        .loss_event_ep(loss_event_ep));
    cpes_frame_model i_cpes_frame_model (.clk_sys(clk_sys), .frm_valid(frm_valid),
        .frm_ep(frm_ep), .frm_ccm_ok(frm_ccm_ok), .frm_bfd_ok(frm_bfd_ok),
        .frm_tx_ccm(frm_tx_ccm), .frm_extract_taken(frm_extract_taken),
        .frm_as_ccm_lm(frm_as_ccm_lm));

    initial forever #10 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        if (loss_event === 1'b1) begin
            n_loss++;
            loss_ep = loss_event_ep;
        end
        if (x_bits !== 5'h0) x_seen = {x_ss, x_bits};
    end
    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task acc(input logic w, input logic [5:0] a, input logic [31:0] v);
        av_a <= a;
        av_wd <= v;
        av_wr <= w;
        av_rd <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        d = avs_readdata;
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task ep_cfg(input logic [7:0] e, input logic [31:0] v);
        acc(1'b1, CPES_A_EPSEL, {24'h0, e});
        acc(1'b1, CPES_A_EPCFG, v);
    endtask
    task ep_st(input logic [7:0] e);
        acc(1'b1, CPES_A_EPSEL, {24'h0, e});
        acc(1'b0, CPES_A_EPST, 32'h0);
    endtask
    // idle gaps let the scan run, since every bus cycle stalls it
    task wait_done;
        for (int i = 0; i < 20; i++) begin
            repeat (60) @(posedge clk_sys);
            acc(1'b0, CPES_A_STAT, 32'h0);
            if (d[CPES_B_DONE] === 1'b1) break;
        end
        chk(d[CPES_B_DONE], 32'h1);
        acc(1'b1, CPES_A_STAT, 32'h00070000);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_reset;
        acc(1'b0, CPES_A_TICK, 32'h0);
        chk(d, 32'h0000C350);
        acc(1'b0, CPES_A_STAT, 32'h0);
        chk(d, 32'h0);
    endtask
    task t_force;
        acc(1'b1, CPES_A_CTRL, 32'h3);
        ep_cfg(8'h05, 32'h0);
        acc(1'b1, CPES_A_FORCE, 32'h1);
        acc(1'b0, CPES_A_STAT, 32'h0);
        chk(d & 32'h000101FF, 32'h00010001);
        wait_done;
        ep_st(8'h06);
        chk(d[3:0], 32'h0);
        ep_st(8'h05);
        chk(d[5:0], 32'h21);
        i_cpes_frame_model.send(8'h05, 4'h4);
        chk(i_cpes_frame_model.lm_hits, 32'h1);
    endtask
    task t_loss;
        repeat (6) begin
            acc(1'b1, CPES_A_FORCE, 32'h1);
            wait_done;
        end
        chk(n_loss, 32'h1);
        chk(loss_ep, 32'h5);
        ep_st(8'h05);
        chk(d[4:0], 32'h17);
        acc(1'b1, CPES_A_CTRL, 32'h2);
        i_cpes_frame_model.send(8'h05, 4'h1);
        ep_st(8'h05);
        chk(d[3:0], 32'h7);
        acc(1'b1, CPES_A_CTRL, 32'h3);
        i_cpes_frame_model.send(8'h05, 4'h1);
        ep_st(8'h05);
        chk(d[4:0], 32'h0);
    endtask
    task t_extract;
        ep_cfg(8'h09, 32'h0000CDFE);
        ep_cfg(8'h0A, 32'h0000057E);
        acc(1'b1, CPES_A_FSLOT, 32'h3);
        acc(1'b1, CPES_A_GTMR, 32'h2);
        acc(1'b1, CPES_A_FORCE, 32'h80);
        wait_done;
        ep_st(8'h09);
        chk(d[11:6], 32'h31);
        ep_st(8'h0A);
        chk(d[11:6], 32'h0);
        i_cpes_frame_model.send(8'h09, 4'h8);
        chk(x_seen, 32'h31);
        ep_st(8'h09);
        chk(d[11:6], 32'h0);
    endtask
    task t_timer;
        acc(1'b1, CPES_A_CTRL, 32'h1);
        acc(1'b1, CPES_A_TICK, 32'h3);
        acc(1'b1, CPES_A_PER0, 32'h2);
        repeat (100) @(posedge clk_sys);
        acc(1'b0, CPES_A_STAT, 32'h0);
        chk(d[18:16], 32'h0);
        acc(1'b1, CPES_A_CTRL, 32'h3);
        repeat (100) @(posedge clk_sys);
        acc(1'b0, CPES_A_STAT, 32'h0);
        chk(d[18:16], 32'h5);
        acc(1'b1, CPES_A_CTRL, 32'h1);
        acc(1'b0, CPES_A_STAT, 32'h0);
        chk(d[8:0], 32'h0);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset;
        t_force;
        t_loss;
        t_extract;
        t_timer;
        tally_and_finish;
    end
endmodule
